/* File: dsr_pkg.sv */
// constants and types for the drive strength register block
package dsr_pkg;
	// register map
	localparam logic [7:0]  REG_PULLUP    = 8'h05;
	localparam logic [7:0]  REG_PULLDN    = 8'h06;
	localparam logic [7:0]  PTR_RST       = 8'h00;
	localparam logic [7:0]  PTR_STEP      = 8'h01;
	// field layout and reset values
	localparam int          WORD_W        = 16;
	localparam int          FIELD_W       = 4;
	localparam logic [3:0]  STRENGTH_RST  = 4'h0;
	localparam logic [15:0] WORD_RST      = 16'h0000;
	// serial framing
	localparam logic        RW_READ       = 1'b0;
	localparam logic [6:0]  DEV_ADDR_DFLT = 7'h60;
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	localparam logic [3:0]  CNT_ZERO      = 4'h0;
	localparam logic [3:0]  CNT_ONE       = 4'h1;
	// write byte phases
	localparam logic [1:0]  PH_PTR        = 2'h0;
	localparam logic [1:0]  PH_MSB        = 2'h1;
	localparam logic [1:0]  PH_LSB        = 2'h2;
	// link sequencer states
	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_AACK,
		ST_WRITE,
		ST_WACK,
		ST_READ,
		ST_RACK
	} dsr_state_t;
endpackage

/* File: dsr_cross_if.sv */
// strength fields and update toggle crossing into the system clock
`timescale 1ns/1ps
`default_nettype none
interface dsr_cross_if;
	logic       tgl;
	logic [3:0] pu;
	logic [3:0] pd;
	modport src (output tgl, output pu, output pd);
	modport dst (input tgl, input pu, input pd);
endinterface
`default_nettype wire

/* File: dsr_apply.sv */
// system clock side that applies new strength codes to the driver
`timescale 1ns/1ps
`default_nettype none
module dsr_apply
	import dsr_pkg::*;
(
	// system
	input  wire logic               clock,
	input  wire logic               sys_rst,
	// from link domain
	dsr_cross_if.dst                xing,
	// driver controls
	output logic [FIELD_W-1:0]      pullup_strength,
	output logic [FIELD_W-1:0]      pulldown_strength
);
	logic tgl_meta_reg;
	logic tgl_s_reg;
	logic tgl_p_reg;
	logic apply;

	// toggle synchroniser
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tgl_meta_reg <= 1'b0;
			tgl_s_reg    <= 1'b0;
			tgl_p_reg    <= 1'b0;
		end else begin
			tgl_meta_reg <= xing.tgl;
			tgl_s_reg    <= tgl_meta_reg;
			tgl_p_reg    <= tgl_s_reg;
		end
	end

	assign apply = tgl_s_reg ^ tgl_p_reg;

	// fields are stable while the toggle crosses
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pullup_strength   <= STRENGTH_RST;
			pulldown_strength <= STRENGTH_RST;
		end else if (apply) begin
			pullup_strength   <= xing.pu;
			pulldown_strength <= xing.pd;
		end
	end

	strength_apply_a: assert property (@(posedge clock) disable iff (sys_rst)
		apply |=> (pullup_strength == $past(xing.pu)) && (pulldown_strength == $past(xing.pd)))
		else $error("strength code not applied after update");
	strength_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		!apply |=> $stable(pullup_strength) && $stable(pulldown_strength))
		else $error("strength code changed without update");
	apply_seen_c: cover property (@(posedge clock) disable iff (sys_rst) apply);
endmodule // dsr_apply
`default_nettype wire

/* File: dsr_i2c_slave.sv */
// two-wire target holding the output driver strength registers
`timescale 1ns/1ps
`default_nettype none
// Contract
// - target only, clock up to 1 MHz
// - data stable while clock high
// - data changes only while clock low
// - one data change per low phase
// - idle bus lines released, pulled high
// - data fall with clock high is START
// - data rise with clock high is STOP
// - repeated START begins a new transfer
// - reg 0x05 bits 3:0 set pull-up
// - reg 0x06 bits 3:0 set pull-down
// - bits 15:4 read zero, writes ignored
// - both fields reset to code zero
// - 8-bit pointer auto-increments, wraps 255 to 0
// - two bytes, MSB byte first, MSB first
// - ninth pulse acknowledges, receiver holds data low
// - refuse only a foreign target address
module dsr_i2c_slave
	import dsr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
	// system
	input  wire logic               clock,
	input  wire logic               sys_rst,
	// two-wire link
	input  wire logic               link_clk,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe,
	// driver controls
	output logic [FIELD_W-1:0]      pullup_strength,
	output logic [FIELD_W-1:0]      pulldown_strength
);
	dsr_state_t          state_reg;
	logic                rst_meta_reg;
	logic                link_rst_reg;
	logic                scl_meta_reg;
	logic                scl_s_reg;
	logic                scl_p_reg;
	logic                sda_meta_reg;
	logic                sda_s_reg;
	logic                sda_p_reg;
	logic [3:0]          cnt_reg;
	logic                rd_reg;
	logic                mack_reg;
	logic [7:0]          rx_reg;
	logic [7:0]          lo_reg;
	logic [7:0]          ptr_reg;
	logic [1:0]          phase_reg;
	logic [7:0]          tx_reg;
	logic                rhalf_reg;
	logic                sda_oe_reg;
	logic                sda_out_reg;
	logic [FIELD_W-1:0]  pu_reg;
	logic [FIELD_W-1:0]  pd_reg;
	logic                tgl_reg;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_ev;
	logic                stop_ev;
	logic                byte_done;
	logic                addr_hit;
	logic                commit;
	logic [WORD_W-1:0]   cur_word;
	logic [WORD_W-1:0]   nxt_word;

	dsr_cross_if xing ();

	// read value of a register, unmapped reads zero
	function automatic logic [WORD_W-1:0] reg_word(
		input logic [7:0]         a,
		input logic [FIELD_W-1:0] pu,
		input logic [FIELD_W-1:0] pd
	);
		case (a)
			REG_PULLUP: reg_word = {{(WORD_W-FIELD_W){1'b0}}, pu};
			REG_PULLDN: reg_word = {{(WORD_W-FIELD_W){1'b0}}, pd};
			default:    reg_word = WORD_RST;
		endcase
	endfunction

	// reset into the link domain
	always_ff @(posedge link_clk) begin
		rst_meta_reg <= sys_rst;
		link_rst_reg <= rst_meta_reg;
	end

	// pin synchronisers, clock pin is only sampled
	always_ff @(posedge link_clk) begin
		if (link_rst_reg) begin
			scl_meta_reg <= 1'b1;
			scl_s_reg    <= 1'b1;
			scl_p_reg    <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_s_reg    <= 1'b1;
			sda_p_reg    <= 1'b1;
		end else begin
			scl_meta_reg <= scl_in;
			scl_s_reg    <= scl_meta_reg;
			scl_p_reg    <= scl_s_reg;
			sda_meta_reg <= sda_in;
			sda_s_reg    <= sda_meta_reg;
			sda_p_reg    <= sda_s_reg;
		end
	end

	// bus events
	assign scl_rise  = scl_s_reg & ~scl_p_reg;
	assign scl_fall  = ~scl_s_reg & scl_p_reg;
	assign start_ev  = scl_s_reg & scl_p_reg & sda_p_reg & ~sda_s_reg;
	assign stop_ev   = scl_s_reg & scl_p_reg & ~sda_p_reg & sda_s_reg;
	assign byte_done = scl_fall && (cnt_reg == BITS_PER_BYTE);
	assign addr_hit  = (rx_reg[7:1] == DEV_ADDR);
	assign commit    = (state_reg == ST_WACK) && scl_fall && (phase_reg == PH_LSB);
	assign cur_word  = reg_word(ptr_reg, pu_reg, pd_reg);
	assign nxt_word  = reg_word(ptr_reg + PTR_STEP, pu_reg, pd_reg);

	// sequencer and bit counter
	always_ff @(posedge link_clk) begin
		if (link_rst_reg) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= CNT_ZERO;
			rd_reg    <= 1'b0;
			mack_reg  <= 1'b0;
		end else if (start_ev) begin
			state_reg <= ST_ADDR;
			cnt_reg   <= CNT_ZERO;
		end else if (stop_ev) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= CNT_ZERO;
		end else begin
			case (state_reg)
				ST_ADDR: begin
					if (scl_rise)
						cnt_reg <= cnt_reg + CNT_ONE;
					if (byte_done) begin
						cnt_reg <= CNT_ZERO;
						rd_reg  <= (rx_reg[0] == RW_READ);
						if (addr_hit)
							state_reg <= ST_AACK;
						else
							state_reg <= ST_IDLE;
					end
				end
				ST_WRITE: begin
					if (scl_rise)
						cnt_reg <= cnt_reg + CNT_ONE;
					if (byte_done) begin
						cnt_reg   <= CNT_ZERO;
						state_reg <= ST_WACK;
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						if (rd_reg) begin
							state_reg <= ST_READ;
							cnt_reg   <= CNT_ONE;
						end else begin
							state_reg <= ST_WRITE;
							cnt_reg   <= CNT_ZERO;
						end
					end
				end
				ST_WACK: begin
					if (scl_fall)
						state_reg <= ST_WRITE;
				end
				ST_READ: begin
					if (scl_fall) begin
						if (cnt_reg == BITS_PER_BYTE) begin
							state_reg <= ST_RACK;
							cnt_reg   <= CNT_ZERO;
						end else begin
							cnt_reg <= cnt_reg + CNT_ONE;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise)
						mack_reg <= ~sda_s_reg;
					if (scl_fall) begin
						if (mack_reg) begin
							state_reg <= ST_READ;
							cnt_reg   <= CNT_ONE;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// receive shifter, msb arrives first
	always_ff @(posedge link_clk) begin
		if (link_rst_reg)
			rx_reg <= 8'h00;
		else if (scl_rise && (state_reg == ST_ADDR || state_reg == ST_WRITE))
			rx_reg <= {rx_reg[6:0], sda_s_reg};
	end

	// pointer, write phases and register storage
	always_ff @(posedge link_clk) begin
		if (link_rst_reg) begin
			ptr_reg   <= PTR_RST;
			phase_reg <= PH_PTR;
			lo_reg    <= 8'h00;
			pu_reg    <= STRENGTH_RST;
			pd_reg    <= STRENGTH_RST;
			tgl_reg   <= 1'b0;
		end else if (start_ev) begin
			phase_reg <= PH_PTR;
		end else if (state_reg == ST_WRITE && byte_done) begin
			if (phase_reg == PH_PTR)
				ptr_reg <= rx_reg;
			if (phase_reg == PH_LSB)
				lo_reg <= rx_reg;
		end else if (state_reg == ST_WACK && scl_fall) begin
			phase_reg <= (phase_reg == PH_MSB) ? PH_LSB : PH_MSB;
			if (commit) begin
				ptr_reg <= ptr_reg + PTR_STEP;
				if (ptr_reg == REG_PULLUP) begin
					pu_reg  <= lo_reg[FIELD_W-1:0];
					tgl_reg <= ~tgl_reg;
				end
				if (ptr_reg == REG_PULLDN) begin
					pd_reg  <= lo_reg[FIELD_W-1:0];
					tgl_reg <= ~tgl_reg;
				end
			end
		end else if (state_reg == ST_RACK && scl_fall && mack_reg && rhalf_reg) begin
			ptr_reg <= ptr_reg + PTR_STEP;
		end
	end

	// data line driver, changes only on clock falls
	always_ff @(posedge link_clk) begin
		if (link_rst_reg) begin
			sda_oe_reg  <= 1'b0;
			sda_out_reg <= 1'b0;
			tx_reg      <= 8'h00;
			rhalf_reg   <= 1'b0;
		end else if (start_ev || stop_ev) begin
			sda_oe_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_ADDR: begin
					if (byte_done)
						sda_oe_reg <= addr_hit;
				end
				ST_WRITE: begin
					if (byte_done)
						sda_oe_reg <= 1'b1;
				end
				ST_AACK: begin
					if (scl_fall) begin
						rhalf_reg <= 1'b0;
						if (rd_reg) begin
							sda_oe_reg <= ~cur_word[15];
							tx_reg     <= {cur_word[14:8], 1'b0};
						end else begin
							sda_oe_reg <= 1'b0;
						end
					end
				end
				ST_WACK: begin
					if (scl_fall)
						sda_oe_reg <= 1'b0;
				end
				ST_READ: begin
					if (scl_fall) begin
						if (cnt_reg == BITS_PER_BYTE) begin
							sda_oe_reg <= 1'b0;
						end else begin
							sda_oe_reg <= ~tx_reg[7];
							tx_reg     <= {tx_reg[6:0], 1'b0};
						end
					end
				end
				ST_RACK: begin
					if (scl_fall && mack_reg) begin
						rhalf_reg <= ~rhalf_reg;
						if (!rhalf_reg) begin
							sda_oe_reg <= ~cur_word[7];
							tx_reg     <= {cur_word[6:0], 1'b0};
						end else begin
							sda_oe_reg <= ~nxt_word[15];
							tx_reg     <= {nxt_word[14:8], 1'b0};
						end
					end
				end
				default: begin
					sda_oe_reg <= 1'b0;
				end
			endcase
		end
	end

	assign xing.tgl = tgl_reg;
	assign xing.pu  = pu_reg;
	assign xing.pd  = pd_reg;
	assign sda_oe   = sda_oe_reg;
	assign sda_out  = sda_out_reg;

	dsr_apply u_apply (
		.clock             (clock),
		.sys_rst           (sys_rst),
		.xing              (xing.dst),
		.pullup_strength   (pullup_strength),
		.pulldown_strength (pulldown_strength)
	);

	default clocking link_cb @(posedge link_clk);
	endclocking
	default disable iff (link_rst_reg);

	idle_release_a: assert property (state_reg == ST_IDLE |-> !sda_oe_reg)
		else $error("data line driven while idle");
	data_stable_a: assert property ($changed(sda_oe_reg) |-> !$past(scl_s_reg))
		else $error("data line changed while clock high");
	one_change_a: assert property ($changed(sda_oe_reg) |-> $past(scl_fall))
		else $error("data line changed away from clock fall");
	start_seen_a: assert property (start_ev |=> state_reg == ST_ADDR && cnt_reg == CNT_ZERO)
		else $error("start not taken");
	stop_seen_a: assert property (stop_ev |=> state_reg == ST_IDLE && !sda_oe_reg)
		else $error("stop not taken");
	addr_nack_a: assert property (state_reg == ST_ADDR && byte_done && !addr_hit
		|=> state_reg == ST_IDLE && !sda_oe_reg)
		else $error("foreign address acknowledged");
	ack_drive_a: assert property ((state_reg == ST_WRITE || (state_reg == ST_ADDR && addr_hit))
		&& byte_done |=> sda_oe_reg ##1 sda_oe_reg)
		else $error("acknowledge not driven");
	ack_hold_a: assert property ((state_reg == ST_WACK || state_reg == ST_AACK)
		&& !scl_fall && !start_ev && !stop_ev |=> sda_oe_reg)
		else $error("acknowledge released early");
	ptr_wrap_a: assert property (commit && ptr_reg == 8'hFF |=> ptr_reg == PTR_RST)
		else $error("pointer did not wrap");
	pullup_write_a: assert property (commit && ptr_reg == REG_PULLUP
		|=> pu_reg == $past(lo_reg[FIELD_W-1:0]) && tgl_reg != $past(tgl_reg))
		else $error("pull-up write lost");
	pulldn_write_a: assert property (commit && ptr_reg == REG_PULLDN
		|=> pd_reg == $past(lo_reg[FIELD_W-1:0]) && tgl_reg != $past(tgl_reg))
		else $error("pull-down write lost");
	upper_zero_a: assert property (cur_word[WORD_W-1:FIELD_W] == '0)
		else $error("upper bits not zero");
	msb_first_a: assert property (state_reg == ST_READ && scl_fall && cnt_reg != BITS_PER_BYTE
		|=> sda_oe_reg == !$past(tx_reg[7]))
		else $error("read bit order wrong");

	write_commit_c: cover property (commit);
	read_ack_c: cover property (state_reg == ST_RACK && scl_fall && mack_reg);
	addr_nack_c: cover property (state_reg == ST_ADDR && byte_done && !addr_hit);
	restart_c: cover property (start_ev && state_reg != ST_IDLE);
endmodule // dsr_i2c_slave
`default_nettype wire

/* File: dsr_bus_master.sv */
// two-wire bus controller model driving the target under test
`timescale 1ns/1ps
`default_nettype none
module dsr_bus_master
	import dsr_pkg::*;
#(
	parameter int HALF = 20
) (
	// system
	input  wire logic        clock,
	// bus
	input  wire logic        sda_in,
	output logic             scl_out,
	output logic             sda_drv,
	// results
	output logic             res_valid,
	output logic [15:0]      res_data
);
	// idle bus released, lines pulled high
	initial begin
		scl_out = 1'b1;
		sda_drv = 1'b1;
		res_valid = 1'b0;
		res_data = 16'h0000;
	end
	// one phase of 1 us keeps the bit rate well under 1 MHz
	task automatic ph();
		repeat (HALF) @(posedge clock);
		#2;
	endtask
	task automatic report(input logic [15:0] v);
		@(posedge clock);
		#2;
		res_data = v;
		res_valid = 1'b1;
		@(posedge clock);
		#2;
		res_valid = 1'b0;
	endtask
	// one bit: data set once in the low phase, held while clock high
	task automatic bit_io(input logic b, output logic s);
		repeat (8) @(posedge clock);
		#2;
		sda_drv = b;
		ph();
		scl_out = 1'b1;
		ph();
		s = sda_in;
		scl_out = 1'b0;
	endtask
	task automatic start();
		ph();
		sda_drv = 1'b0;
		ph();
		scl_out = 1'b0;
	endtask
	task automatic rstart();
		repeat (8) @(posedge clock);
		#2;
		sda_drv = 1'b1;
		ph();
		scl_out = 1'b1;
		ph();
		sda_drv = 1'b0;
		ph();
		scl_out = 1'b0;
	endtask
	task automatic stop();
		repeat (8) @(posedge clock);
		#2;
		sda_drv = 1'b0;
		ph();
		scl_out = 1'b1;
		ph();
		sda_drv = 1'b1;
		ph();
	endtask
	// byte out msb first, data released in the ninth pulse
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, ack);
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, b[i]);
		end
		bit_io(nack, s);
	endtask
endmodule // dsr_bus_master
`default_nettype wire

/* File: dsr_i2c_slave_bench.sv */
// self-checking bench for the drive strength target
`timescale 1ns/1ps
`default_nettype none
module dsr_i2c_slave_bench
	import dsr_pkg::*;
;
	localparam logic [7:0] WR_ADDR = {DEV_ADDR_DFLT, ~RW_READ};
	localparam logic [7:0] RD_ADDR = {DEV_ADDR_DFLT, RW_READ};
	logic        clock;
	logic        sys_rst;
	logic        link_clk;
	logic        scl_line;
	logic        sda_drv;
	wire logic   sda_line;
	logic        sda_out;
	logic        sda_oe;
	logic [3:0]  pullup_strength;
	logic [3:0]  pulldown_strength;
	logic        res_valid;
	logic [15:0] res_data;
	logic        str_req;
	logic [15:0] got;
	logic [15:0] exp_v;
	logic [15:0] w0;
	logic [15:0] w1;
	logic [15:0] w2;
	logic [15:0] wv;
	logic [15:0] exp_q[$];
	int          err_total;
	int          checks;
	// open-drain wire-and of both parties
	assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
	dsr_i2c_slave #(.DEV_ADDR(DEV_ADDR_DFLT)) u_dut (
		.clock             (clock),
		.sys_rst           (sys_rst),
		.link_clk          (link_clk),
		.scl_in            (scl_line),
		.sda_in            (sda_line),
		.sda_out           (sda_out),
		.sda_oe            (sda_oe),
		.pullup_strength   (pullup_strength),
		.pulldown_strength (pulldown_strength)
	);
	dsr_bus_master u_master (
		.clock     (clock),
		.sda_in    (sda_line),
		.scl_out   (scl_line),
		.sda_drv   (sda_drv),
		.res_valid (res_valid),
		.res_data  (res_data)
	);
	initial begin
		clock = 1'b0;
		link_clk = 1'b0;
		sys_rst = 1'b1;
		str_req = 1'b0;
		err_total = 0;
		checks = 0;
	end
	always #25 clock = ~clock;
	initial begin
		#17;
		forever #62.5 link_clk = ~link_clk;
	end
	task automatic stop_test();
		if (err_total == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic tx(input logic [7:0] b, input logic exp_ack);
		logic a;
		exp_q.push_back({15'h0000, exp_ack});
		u_master.wbyte(b, a);
		u_master.report({15'h0000, a});
	endtask
	task automatic rx(input logic [7:0] e, input logic nack);
		logic [7:0] d;
		exp_q.push_back({8'h00, e});
		u_master.rbyte(nack, d);
		u_master.report({8'h00, d});
	endtask
	task automatic probe(input logic [15:0] e);
		exp_q.push_back(e);
		repeat (10) @(posedge clock);
		#2;
		str_req = 1'b1;
		@(posedge clock);
		#2;
		str_req = 1'b0;
	endtask
	task automatic do_reset();
		#2;
		sys_rst = 1'b1;
		repeat (16) @(posedge clock);
		#2;
		sys_rst = 1'b0;
		repeat (40) @(posedge clock);
	endtask
	// result monitor
	always @(posedge clock) begin
		if (res_valid === 1'b1 || str_req === 1'b1) begin
			got = res_valid ? res_data : {8'h00, pullup_strength, pulldown_strength};
			exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFFFF;
			checks++;
			if (got !== exp_v) begin
				err_total++;
				$display("Error at %0t: got %h expected %h", $time, got, exp_v);
			end
		end
	end
	// target may only move data while clock low
	always @(sda_oe) begin
		if (scl_line === 1'b1 && sys_rst === 1'b0) begin
			err_total++;
			$display("Error at %0t: data moved with clock high %h", $time, sda_oe);
		end
	end
	initial begin
		#3_000_000;
		err_total++;
		stop_test();
	end
	initial begin
		void'($urandom(93));
		do_reset();
		probe(16'h0000);
		w0 = 16'($urandom);
		w1 = 16'($urandom);
		w2 = 16'($urandom);
		u_master.start();
		tx(WR_ADDR, 1'b0);
		tx(REG_PULLUP, 1'b0);
		tx(w0[15:8], 1'b0);
		tx(w0[7:0], 1'b0);
		tx(w1[15:8], 1'b0);
		tx(w1[7:0], 1'b0);
		u_master.stop();
		probe({8'h00, w0[3:0], w1[3:0]});
		u_master.start();
		tx(WR_ADDR, 1'b0);
		tx(REG_PULLUP, 1'b0);
		u_master.rstart();
		tx(RD_ADDR, 1'b0);
		rx(8'h00, 1'b0);
		rx({4'h0, w0[3:0]}, 1'b0);
		rx(8'h00, 1'b0);
		rx({4'h0, w1[3:0]}, 1'b1);
		u_master.stop();
		u_master.start();
		tx(WR_ADDR ^ 8'h02, 1'b1);
		u_master.stop();
		u_master.start();
		tx(WR_ADDR, 1'b0);
		tx(REG_PULLDN, 1'b0);
		tx(8'h0F, 1'b0);
		u_master.rstart();
		tx(WR_ADDR, 1'b0);
		tx(8'hFF, 1'b0);
		for (int k = 0; k < 7; k++) begin
			wv = (k == 6) ? w2 : 16'($urandom);
			tx(wv[15:8], 1'b0);
			tx(wv[7:0], 1'b0);
		end
		u_master.stop();
		probe({8'h00, w2[3:0], w1[3:0]});
		do_reset();
		probe(16'h0000);
		stop_test();
	end
endmodule // dsr_i2c_slave_bench
`default_nettype wire
